/* core/zpc_pkg.sv */
// constants and types for the zero-point counter control block
package zpc_pkg;

	localparam int ZPC_AXES = 2;
	localparam int ZPC_CNT_W = 32;
	localparam int ZPC_DIGITS = 7;
	localparam logic [3:0] ZPC_DIGIT_MAX = 4'h9;
	localparam logic [3:0] ZPC_SEL_SIGN = 4'h7;
	localparam logic [3:0] ZPC_SEL_POINT = 4'h8;
	localparam logic [2:0] ZPC_POINT_MAX = 3'h6;

	// timing
	localparam int ZPC_CLK_NS = 5;
	localparam int ZPC_BLINK_HALF_NS = 250000000;
	localparam int ZPC_BLINK_HALF_CYC = ZPC_BLINK_HALF_NS / ZPC_CLK_NS;

	// synchronised input vector positions
	localparam int ZPC_IN_FUNC = 0;
	localparam int ZPC_IN_ENTER = 1;
	localparam int ZPC_IN_RST_A = 2;
	localparam int ZPC_IN_RST_B = 3;
	localparam int ZPC_IN_INC = 4;
	localparam int ZPC_IN_NEXT = 5;
	localparam int ZPC_IN_STORE = 6;
	localparam int ZPC_IN_EXT = 7;
	localparam int ZPC_IN_ZM = 9;
	localparam int ZPC_IN_UP = 11;
	localparam int ZPC_IN_DN = 13;
	localparam int ZPC_NSYNC = 15;

	// register word indices (byte address bits 5:2)
	localparam int ZPC_ADDR_W = 6;
	localparam logic [3:0] ZPC_REG_CTRL = 4'h0;
	localparam logic [3:0] ZPC_REG_STATUS = 4'h1;
	localparam logic [3:0] ZPC_REG_POS0 = 4'h2;
	localparam logic [3:0] ZPC_REG_POS1 = 4'h3;
	localparam logic [3:0] ZPC_REG_DISP0 = 4'h4;
	localparam logic [3:0] ZPC_REG_DISP1 = 4'h5;
	localparam logic [3:0] ZPC_REG_MAX0 = 4'h6;
	localparam logic [3:0] ZPC_REG_MAX1 = 4'h7;
	localparam logic [3:0] ZPC_REG_MIN0 = 4'h8;
	localparam logic [3:0] ZPC_REG_MIN1 = 4'h9;
	localparam logic [3:0] ZPC_REG_STORED0 = 4'ha;
	localparam logic [3:0] ZPC_REG_STORED1 = 4'hb;
	localparam logic [3:0] ZPC_REG_ENTRY = 4'hc;
	localparam logic [3:0] ZPC_REG_ENTRY_CFG = 4'hd;
	localparam logic [3:0] ZPC_REG_LAST = 4'hd;

	// field positions: ctrl bits 1:0 reference mode per axis
	localparam int ZPC_CTRL_REF = 0;
	localparam int ZPC_ST_MENU = 0;
	localparam int ZPC_ST_ITEM = 4;
	localparam int ZPC_ST_AXIS = 6;
	localparam int ZPC_ST_REF = 8;
	localparam int ZPC_ST_HOLD = 10;
	localparam int ZPC_ST_WAIT = 12;
	localparam logic [1:0] ZPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ZPC_RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ZPC_ITEM_ZERO_MARK_LOAD = 2'h0,
		ZPC_ITEM_ZERO_MARK_FREEZE = 2'h1,
		ZPC_ITEM_ZERO_MARK_SHIFT_LOAD = 2'h2,
		ZPC_ITEM_ZERO_MARK_SHIFT_FROM_STORED = 2'h3
	} zpc_item_t;

	typedef enum logic [3:0] {
		ZPC_M_IDLE = 4'b0001,
		ZPC_M_AXIS = 4'b0010,
		ZPC_M_ITEM = 4'b0100,
		ZPC_M_ENTRY = 4'b1000
	} zpc_menu_t;

	typedef enum logic [2:0] {
		ZPC_W_NONE = 3'b001,
		ZPC_W_LOAD = 3'b010,
		ZPC_W_FREEZE = 3'b100
	} zpc_wait_t;

endpackage : zpc_pkg

/* core/zpc_sync_edge.sv */
// two-stage synchroniser with rising-edge pulse per bit
`timescale 1ns/1ps
module zpc_sync_edge #(
	parameter int W = 1
) (
	input logic aclk,
	input logic aresetn,
	input logic [W-1:0] pin,
	output logic [W-1:0] rise
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;

	// only sync_q and last_q feed the edge detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
			rise <= '0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
			rise <= sync_q & ~last_q;
		end
	end

endmodule : zpc_sync_edge

/* core/zpc_top.sv */
// zero-point counter control for two axes with axi4-lite register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module zpc_top #(
	parameter int BLINK_CYCLES = zpc_pkg::ZPC_BLINK_HALF_CYC
) (
	input logic aclk,
	input logic aresetn,
	input logic key_func,
	input logic key_enter,
	input logic key_reset_a,
	input logic key_reset_b,
	input logic key_digit_inc,
	input logic key_digit_next,
	input logic key_store,
	input logic [1:0] ext_reset,
	input logic [1:0] zero_mark,
	input logic [1:0] count_up,
	input logic [1:0] count_dn,
	input logic awvalid,
	output logic awready,
	input logic [zpc_pkg::ZPC_ADDR_W-1:0] awaddr,
	input logic wvalid,
	output logic wready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	output logic bvalid,
	input logic bready,
	output logic [1:0] bresp,
	input logic arvalid,
	output logic arready,
	input logic [zpc_pkg::ZPC_ADDR_W-1:0] araddr,
	output logic rvalid,
	input logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic [31:0] disp_a,
	output logic [31:0] disp_b,
	output logic [1:0] load_ind,
	output logic [1:0] hold_ind,
	output logic [1:0] ref_ind,
	output zpc_pkg::zpc_menu_t menu_state,
	output zpc_pkg::zpc_item_t menu_item,
	output logic axis_sel
);
	import zpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisation
	logic [ZPC_NSYNC-1:0] pin_vec;
	logic [ZPC_NSYNC-1:0] rise;

	assign pin_vec = {count_dn, count_up, zero_mark, ext_reset, key_store, key_digit_next,
		key_digit_inc, key_reset_b, key_reset_a, key_enter, key_func};

	zpc_sync_edge #(.W(ZPC_NSYNC)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(pin_vec),
		.rise(rise)
	);

	wire k_func = rise[ZPC_IN_FUNC];
	wire k_enter = rise[ZPC_IN_ENTER];
	wire k_rst_a = rise[ZPC_IN_RST_A];
	wire k_rst_b = rise[ZPC_IN_RST_B];
	wire k_inc = rise[ZPC_IN_INC];
	wire k_next = rise[ZPC_IN_NEXT];
	wire k_store = rise[ZPC_IN_STORE];
	wire [1:0] ext_rst = rise[ZPC_IN_EXT +: 2];
	wire [1:0] zm_hit = rise[ZPC_IN_ZM +: 2];
	wire [1:0] step_up = rise[ZPC_IN_UP +: 2];
	wire [1:0] step_dn = rise[ZPC_IN_DN +: 2];

	////////////////////////////////////////////////////////////////////////////////
	// state
	zpc_menu_t menu_q;
	zpc_menu_t menu_d;
	zpc_item_t item_q;
	logic axis_q;
	zpc_wait_t wait_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] pos_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] disp_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] max_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] min_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] stored_q [ZPC_AXES];
	logic signed [ZPC_CNT_W-1:0] off_q [ZPC_AXES];
	logic [1:0] hold_q;
	logic [1:0] ref_q;
	logic [ZPC_DIGITS*4-1:0] dig_q;
	logic [ZPC_DIGITS*4-1:0] dig_d;
	logic sign_q;
	logic [3:0] dsel_q;
	logic [2:0] point_q;
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic ref_wr;
	logic [1:0] ref_wr_val;

	function automatic logic signed [ZPC_CNT_W-1:0] bcd_to_bin(input logic [ZPC_DIGITS*4-1:0] d,
		input logic neg);
		logic [ZPC_CNT_W-1:0] acc;
		acc = '0;
		for (int k = ZPC_DIGITS - 1; k >= 0; k--) begin
			acc = ZPC_CNT_W'(acc * 32'd10) + ZPC_CNT_W'(d[k*4 +: 4]);
		end
		return neg ? -acc : acc;
	endfunction : bcd_to_bin

	////////////////////////////////////////////////////////////////////////////////
	// menu decoding
	wire [1:0] waiting = {wait_q[1] != ZPC_W_NONE, wait_q[0] != ZPC_W_NONE};
	wire abort_all = k_rst_a & (|waiting);
	wire in_menu = menu_q != ZPC_M_IDLE;
	wire exec = (menu_q == ZPC_M_ITEM) & k_enter;
	wire entry_done = (menu_q == ZPC_M_ENTRY) & k_enter;
	wire exec_load = exec & ((item_q == ZPC_ITEM_ZERO_MARK_LOAD) | (item_q == ZPC_ITEM_ZERO_MARK_SHIFT_FROM_STORED));
	wire exec_freeze = exec & (item_q == ZPC_ITEM_ZERO_MARK_FREEZE);
	wire exec_entry = exec & (item_q == ZPC_ITEM_ZERO_MARK_SHIFT_LOAD);
	wire [1:0] axis_onehot = {axis_q, ~axis_q};
	wire [1:0] arm_load = axis_onehot & {2{exec_load | entry_done}};
	wire [1:0] arm_freeze = axis_onehot & {2{exec_freeze}};
	wire signed [ZPC_CNT_W-1:0] entry_bin = bcd_to_bin(dig_q, sign_q);
	wire [1:0] release_frz = hold_q & {2{k_rst_a & ~in_menu}};
	wire [1:0] store_frz = hold_q & {2{k_store}};
	wire rst_a_free = k_rst_a & ~in_menu & ~(|waiting) & ~(|hold_q);
	wire [1:0] ax_rst = ext_rst | {k_rst_b & ~in_menu, rst_a_free};

	always_comb begin
		menu_d = menu_q;
		case (menu_q)
			ZPC_M_IDLE: if (k_func) menu_d = ZPC_M_AXIS;
			ZPC_M_AXIS: if (k_enter) menu_d = ZPC_M_ITEM;
			ZPC_M_ITEM: begin
				if (exec_entry) begin
					menu_d = ZPC_M_ENTRY;
				end else if (exec) begin
					menu_d = ZPC_M_IDLE;
				end
			end
			ZPC_M_ENTRY: if (k_enter) menu_d = ZPC_M_IDLE;
			default: menu_d = ZPC_M_IDLE;
		endcase
		if (k_rst_a) begin
			menu_d = ZPC_M_IDLE;
		end
	end

	// digit entry: inc changes the selected digit, next moves the selection
	always_comb begin
		dig_d = dig_q;
		if (exec_entry) begin
			dig_d = '0;
		end else if ((menu_q == ZPC_M_ENTRY) & k_inc & (dsel_q < ZPC_SEL_SIGN)) begin
			dig_d[dsel_q*4 +: 4] = (dig_q[dsel_q*4 +: 4] == ZPC_DIGIT_MAX) ? 4'h0 :
				4'(dig_q[dsel_q*4 +: 4] + 4'h1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			menu_q <= ZPC_M_IDLE;
			item_q <= ZPC_ITEM_ZERO_MARK_LOAD;
			axis_q <= 1'b0;
			dig_q <= '0;
			sign_q <= 1'b0;
			dsel_q <= 4'h0;
			point_q <= 3'h0;
		end else begin
			menu_q <= menu_d;
			dig_q <= dig_d;
			if (menu_q == ZPC_M_IDLE) begin
				item_q <= ZPC_ITEM_ZERO_MARK_LOAD;
			end else if ((menu_q == ZPC_M_ITEM) & k_func) begin
				item_q <= zpc_item_t'(item_q + 2'h1);
			end
			if ((menu_q == ZPC_M_AXIS) & k_func) begin
				axis_q <= ~axis_q;
			end
			if (exec_entry) begin
				sign_q <= 1'b0;
				dsel_q <= 4'h0;
				point_q <= 3'h0;
			end else if (menu_q == ZPC_M_ENTRY) begin
				if (k_next) begin
					dsel_q <= (dsel_q == ZPC_SEL_POINT) ? 4'h0 : 4'(dsel_q + 4'h1);
				end
				if (k_inc & (dsel_q == ZPC_SEL_SIGN)) begin
					sign_q <= ~sign_q;
				end
				if (k_inc & (dsel_q == ZPC_SEL_POINT)) begin
					point_q <= (point_q == ZPC_POINT_MAX) ? 3'h0 : 3'(point_q + 3'h1);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flash timebase: the indicator flashes at a fixed half period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
			blink_cnt_q <= 32'h0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-axis counting and zero-mark actions
	for (genvar g = 0; g < ZPC_AXES; g++) begin : g_axis
		wire done_load = zm_hit[g] & (wait_q[g] == ZPC_W_LOAD) & ~ax_rst[g];
		wire done_frz = zm_hit[g] & (wait_q[g] == ZPC_W_FREEZE) & ~ax_rst[g];
		wire signed [ZPC_CNT_W-1:0] pos_run = pos_q[g] + ZPC_CNT_W'(step_up[g]) - ZPC_CNT_W'(step_dn[g]);
		wire signed [ZPC_CNT_W-1:0] pos_d = ax_rst[g] ? '0 : (done_load ? off_q[g] : pos_run);
		wire keep_disp = hold_q[g] & ~release_frz[g] & ~store_frz[g] & ~ax_rst[g];
		wire signed [ZPC_CNT_W-1:0] arm_val = exec_load & (item_q == ZPC_ITEM_ZERO_MARK_SHIFT_FROM_STORED) ?
			stored_q[g] : (entry_done ? entry_bin : '0);
		zpc_wait_t wait_d;

		assign wait_d = (ax_rst[g] | abort_all | done_load | done_frz) ? ZPC_W_NONE :
			(arm_load[g] ? ZPC_W_LOAD : (arm_freeze[g] ? ZPC_W_FREEZE : wait_q[g]));

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				wait_q[g] <= ZPC_W_NONE;
				pos_q[g] <= '0;
				disp_q[g] <= '0;
				max_q[g] <= '0;
				min_q[g] <= '0;
				stored_q[g] <= '0;
				off_q[g] <= '0;
				hold_q[g] <= 1'b0;
				ref_q[g] <= 1'b0;
				load_ind[g] <= 1'b0;
			end else begin
				wait_q[g] <= wait_d;
				pos_q[g] <= pos_d;
				disp_q[g] <= keep_disp ? disp_q[g] : pos_d;
				if (ax_rst[g] | done_load) begin
					max_q[g] <= pos_d;
					min_q[g] <= pos_d;
				end else begin
					max_q[g] <= (pos_d > max_q[g]) ? pos_d : max_q[g];
					min_q[g] <= (pos_d < min_q[g]) ? pos_d : min_q[g];
				end
				if (store_frz[g]) begin
					stored_q[g] <= disp_q[g];
				end
				if (arm_load[g]) begin
					off_q[g] <= arm_val;
				end
				hold_q[g] <= done_frz | keep_disp;
				if (ax_rst[g] | done_load) begin
					ref_q[g] <= 1'b0;
				end else if (ref_wr) begin
					ref_q[g] <= ref_wr_val[g];
				end
				load_ind[g] <= (wait_d == ZPC_W_LOAD) & blink_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic aw_have_q;
	logic w_have_q;
	logic [3:0] awidx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	wire aw_hs = awvalid & awready;
	wire w_hs = wvalid & wready;
	wire ar_hs = arvalid & arready;
	wire wr_fire = aw_have_q & w_have_q;
	wire aw_have_d = ~wr_fire & (aw_hs | aw_have_q);
	wire w_have_d = ~wr_fire & (w_hs | w_have_q);
	wire bvalid_d = wr_fire | (bvalid & ~bready);
	wire rvalid_d = ar_hs | (rvalid & ~rready);
	wire [3:0] aridx = araddr[5:2];
	wire wr_mapped = awidx_q <= ZPC_REG_LAST;
	assign ref_wr = wr_fire & (awidx_q == ZPC_REG_CTRL) & wstrb_q[0];
	assign ref_wr_val = wdata_q[ZPC_CTRL_REF +: 2];

	wire [31:0] rd_word [16];
	assign rd_word[ZPC_REG_CTRL] = {30'h0, ref_q};
	assign rd_word[ZPC_REG_STATUS] = {14'h0, wait_q[1], wait_q[0], hold_q, ref_q, 1'b0, axis_q, item_q, menu_q};
	assign rd_word[ZPC_REG_POS0] = pos_q[0];
	assign rd_word[ZPC_REG_POS1] = pos_q[1];
	assign rd_word[ZPC_REG_DISP0] = disp_q[0];
	assign rd_word[ZPC_REG_DISP1] = disp_q[1];
	assign rd_word[ZPC_REG_MAX0] = max_q[0];
	assign rd_word[ZPC_REG_MAX1] = max_q[1];
	assign rd_word[ZPC_REG_MIN0] = min_q[0];
	assign rd_word[ZPC_REG_MIN1] = min_q[1];
	assign rd_word[ZPC_REG_STORED0] = stored_q[0];
	assign rd_word[ZPC_REG_STORED1] = stored_q[1];
	assign rd_word[ZPC_REG_ENTRY] = {4'h0, dig_q};
	assign rd_word[ZPC_REG_ENTRY_CFG] = {24'h0, point_q, sign_q, dsel_q};
	assign rd_word[14] = 32'h0;
	assign rd_word[15] = 32'h0;
	wire rd_mapped = aridx <= ZPC_REG_LAST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awidx_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= ZPC_RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= ZPC_RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			if (aw_hs) begin
				awidx_q <= awaddr[5:2];
			end
			if (w_hs) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			awready <= ~aw_have_d & ~bvalid_d;
			wready <= ~w_have_d & ~bvalid_d;
			bvalid <= bvalid_d;
			if (wr_fire) begin
				bresp <= wr_mapped ? ZPC_RESP_OKAY : ZPC_RESP_DECERR;
			end
			arready <= ~rvalid_d;
			rvalid <= rvalid_d;
			if (ar_hs) begin
				rdata <= rd_mapped ? rd_word[aridx] : 32'h0;
				rresp <= rd_mapped ? ZPC_RESP_OKAY : ZPC_RESP_DECERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			disp_a <= 32'h0;
			disp_b <= 32'h0;
			hold_ind <= 2'h0;
			ref_ind <= 2'h0;
			menu_state <= ZPC_M_IDLE;
			menu_item <= ZPC_ITEM_ZERO_MARK_LOAD;
			axis_sel <= 1'b0;
		end else begin
			disp_a <= disp_q[0];
			disp_b <= disp_q[1];
			hold_ind <= hold_q;
			ref_ind <= ref_q;
			menu_state <= menu_q;
			menu_item <= item_q;
			axis_sel <= axis_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire load_done0 = g_axis[0].done_load;
	wire frz_done0 = g_axis[0].done_frz;

	sequence s_freeze_taken;
		frz_done0 ##1 hold_q[0];
	endsequence

	property p_load_count;
		load_done0 |=> pos_q[0] == $past(off_q[0]);
	endproperty
	a_load_count: assert property (p_load_count) else $error("count not restarted at zero mark");

	property p_load_peaks;
		load_done0 |=> (max_q[0] == $past(off_q[0])) && (min_q[0] == $past(off_q[0]));
	endproperty
	a_load_peaks: assert property (p_load_peaks) else $error("peaks not restarted on load");

	property p_load_ref;
		load_done0 |=> !ref_q[0] ##1 !ref_ind[0];
	endproperty
	a_load_ref: assert property (p_load_ref) else $error("reference mode kept after load");

	property p_abort;
		abort_all |=> (wait_q[0] == ZPC_W_NONE) && (wait_q[1] == ZPC_W_NONE);
	endproperty
	a_abort: assert property (p_abort) else $error("wait not aborted by reset key");

	property p_flash_stop;
		load_done0 |=> !load_ind[0] [*2];
	endproperty
	a_flash_stop: assert property (p_flash_stop) else $error("load indicator still flashing");

	property p_freeze_stable;
		s_freeze_taken ##0 (!release_frz[0] && !store_frz[0] && !ax_rst[0]) |=> $stable(disp_q[0]);
	endproperty
	a_freeze_stable: assert property (p_freeze_stable) else $error("frozen display moved");

	property p_freeze_ref;
		frz_done0 && ref_q[0] && !ref_wr |=> ref_q[0];
	endproperty
	a_freeze_ref: assert property (p_freeze_ref) else $error("freeze dropped reference mode");

	property p_freeze_arm;
		arm_freeze[0] && !ax_rst[0] && !abort_all |=> wait_q[0] == ZPC_W_FREEZE;
	endproperty
	a_freeze_arm: assert property (p_freeze_arm) else $error("freeze wait not armed");

	property p_item_step;
		(menu_q == ZPC_M_ITEM) && k_func && !k_rst_a |=> item_q == zpc_item_t'($past(item_q) + 2'h1);
	endproperty
	a_item_step: assert property (p_item_step) else $error("function key did not advance item");

	property p_stored_arm;
		arm_load[0] && (item_q == ZPC_ITEM_ZERO_MARK_SHIFT_FROM_STORED) && !ax_rst[0] && !abort_all
			|=> (wait_q[0] == ZPC_W_LOAD) && (off_q[0] == $past(stored_q[0]));
	endproperty
	a_stored_arm: assert property (p_stored_arm) else $error("stored offset not armed");

	property p_axis_reset;
		ax_rst[1] |=> (wait_q[1] == ZPC_W_NONE) && (pos_q[1] == 0);
	endproperty
	a_axis_reset: assert property (p_axis_reset) else $error("axis reset left wait armed");

endmodule : zpc_top

/* tb/test_zero_point_counter_control.sv */
// self-checking bench for the zero-point counter control block
`timescale 1ns/1ps
module test_zero_point_counter_control;
	import zpc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn, awvalid, wvalid, bready, arvalid, rready, hi, lo;
	logic [8:0] pins;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdat;
	logic [3:0] wstrb;
	logic [1:0] rrsp;
	wire logic awready, wready, bvalid, arready, rvalid, axis_sel;
	wire logic [1:0] bresp, rresp, zero_mark, count_up, count_dn, load_ind, hold_ind, ref_ind;
	wire logic [31:0] rdata, disp_a, disp_b;
	zpc_menu_t menu_state;
	zpc_item_t menu_item;
	int fail_count = 0;
	int checks = 0;

	always #2.5 aclk = ~aclk;

	zpc_scale_model scale (.aclk(aclk), .zero_mark(zero_mark), .count_up(count_up), .count_dn(count_dn));

	zpc_top #(.BLINK_CYCLES(4)) DUT (
		.aclk(aclk), .aresetn(aresetn), .key_func(pins[ZPC_IN_FUNC]), .key_enter(pins[ZPC_IN_ENTER]),
		.key_reset_a(pins[ZPC_IN_RST_A]), .key_reset_b(pins[ZPC_IN_RST_B]), .key_digit_inc(pins[ZPC_IN_INC]),
		.key_digit_next(pins[ZPC_IN_NEXT]), .key_store(pins[ZPC_IN_STORE]), .ext_reset(pins[8:7]),
		.zero_mark(zero_mark), .count_up(count_up), .count_dn(count_dn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.disp_a(disp_a), .disp_b(disp_b), .load_ind(load_ind), .hold_ind(hold_ind), .ref_ind(ref_ind),
		.menu_state(menu_state), .menu_item(menu_item), .axis_sel(axis_sel)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// waits as long as the slave needs; only the watchdog ends a hung transfer
	task automatic axi_write(input logic [3:0] idx, input logic [31:0] d, input logic [3:0] strb,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		@(posedge aclk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (bvalid) begin
				check("bresp", 32'(bresp), 32'(er));
				break;
			end
			if (awready && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok;
		@(posedge aclk);
		ar_ok = 1'b0;
		d = '1;
		r = 2'h1;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
			if (arready && !ar_ok) begin
				ar_ok = 1'b1;
				arvalid <= 1'b0;
			end
		end
		rready <= 1'b0;
	endtask : axi_read

	task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
		axi_read(idx, rdat, rrsp);
		check("register", rdat, exp);
	endtask : rd

	task automatic wait_is(input int ax, input logic [2:0] exp);
		axi_read(ZPC_REG_STATUS, rdat, rrsp);
		check("wait state", 32'(rdat[12 + 3 * ax +: 3]), 32'(exp));
	endtask : wait_is

	// keys are held two cycles, then the bench waits past the pin-to-output latency
	task automatic press(input int k);
		@(posedge aclk);
		pins[k] <= 1'b1;
		repeat (2) @(posedge aclk);
		pins[k] <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : press

	task automatic arm(input int ax, input int item);
		press(ZPC_IN_FUNC);
		if (axis_sel !== ax[0]) begin
			press(ZPC_IN_FUNC);
		end
		check("axis", 32'(axis_sel), 32'(ax));
		press(ZPC_IN_ENTER);
		repeat (item) press(ZPC_IN_FUNC);
		check("item", 32'(menu_item), 32'(item));
		press(ZPC_IN_ENTER);
	endtask : arm
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end

	initial begin
		aresetn = 1'b0;
		pins = '0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 6'h0;
		araddr = 6'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(ZPC_REG_STATUS, 32'h0000_9001);
		axi_read(4'he, rdat, rrsp);
		check("unmapped", {rrsp, rdat[29:0]}, {ZPC_RESP_DECERR, 30'h0});
		axi_write(4'he, 32'h0, 4'hf, ZPC_RESP_DECERR);
		press(ZPC_IN_FUNC);
		check("menu", 32'(menu_state), 32'(ZPC_M_AXIS));
		press(ZPC_IN_ENTER);
		for (int i = 1; i <= 4; i++) begin
			press(ZPC_IN_FUNC);
			check("item", 32'(menu_item), i % 4);
		end
		press(ZPC_IN_RST_A);
		check("menu", 32'(menu_state), 32'(ZPC_M_IDLE));
		// plain load on axis 0 with both axes in reference mode
		scale.step(0, 1'b1, 5);
		axi_write(ZPC_REG_CTRL, 32'h3, 4'hf, ZPC_RESP_OKAY);
		// without the low byte strobe the reference bits must not move
		axi_write(ZPC_REG_CTRL, 32'h0, 4'he, ZPC_RESP_OKAY);
		rd(ZPC_REG_CTRL, 32'h3);
		arm(0, 0);
		wait_is(0, 3'b010);
		hi = 1'b0;
		lo = 1'b0;
		repeat (20) begin
			@(posedge aclk);
			hi |= load_ind[0];
			lo |= !load_ind[0];
		end
		check("blink", 32'({hi, lo}), 32'h3);
		scale.pulse_mark(0);
		check("disp a", disp_a, 32'h0);
		check("load ind", 32'(load_ind), 32'h0);
		check("ref", 32'(ref_ind), 32'h2);
		rd(ZPC_REG_MAX0, 32'h0);
		rd(ZPC_REG_MIN0, 32'h0);
		scale.step(0, 1'b1, 3);
		scale.pulse_mark(0);
		rd(ZPC_REG_POS0, 32'h3);
		// freeze on axis 1, then store the frozen value
		arm(1, 1);
		wait_is(1, 3'b100);
		scale.step(1, 1'b1, 2);
		scale.pulse_mark(1);
		check("hold", 32'(hold_ind), 32'h2);
		check("ref", 32'(ref_ind), 32'h2);
		scale.step(1, 1'b1, 3);
		check("disp b", disp_b, 32'h2);
		rd(ZPC_REG_POS1, 32'h5);
		press(ZPC_IN_STORE);
		check("hold", 32'(hold_ind), 32'h0);
		rd(ZPC_REG_STORED1, 32'h2);
		// offset from the stored value
		arm(1, 3);
		wait_is(1, 3'b010);
		scale.step(1, 1'b1, 4);
		scale.pulse_mark(1);
		rd(ZPC_REG_POS1, 32'h2);
		rd(ZPC_REG_MAX1, 32'h2);
		rd(ZPC_REG_MIN1, 32'h2);
		check("ref", 32'(ref_ind), 32'h0);
		// entered offset -23 on axis 0
		arm(0, 2);
		check("menu", 32'(menu_state), 32'(ZPC_M_ENTRY));
		rd(ZPC_REG_ENTRY, 32'h0);
		repeat (3) press(ZPC_IN_INC);
		press(ZPC_IN_NEXT);
		repeat (2) press(ZPC_IN_INC);
		repeat (6) press(ZPC_IN_NEXT);
		press(ZPC_IN_INC);
		rd(ZPC_REG_ENTRY, 32'h23);
		rd(ZPC_REG_ENTRY_CFG, 32'h17);
		press(ZPC_IN_ENTER);
		wait_is(0, 3'b010);
		scale.pulse_mark(0);
		rd(ZPC_REG_POS0, 32'hffff_ffe9);
		// aborts: reset key and external axis reset
		arm(0, 0);
		press(ZPC_IN_RST_A);
		wait_is(0, 3'b001);
		scale.pulse_mark(0);
		rd(ZPC_REG_POS0, 32'hffff_ffe9);
		arm(1, 1);
		press(ZPC_IN_EXT + 1);
		wait_is(1, 3'b001);
		rd(ZPC_REG_POS1, 32'h0);
		// count down on axis 1, then reset key b cancels its pending load
		scale.step(1, 1'b0, 2);
		rd(ZPC_REG_POS1, 32'hffff_fffe);
		arm(1, 0);
		wait_is(1, 3'b010);
		press(ZPC_IN_RST_B);
		wait_is(1, 3'b001);
		rd(ZPC_REG_MIN1, 32'h0);
		press(ZPC_IN_EXT);
		rd(ZPC_REG_POS0, 32'h0);
		// freeze on axis 0 in reference mode, released by reset a without storing
		axi_write(ZPC_REG_CTRL, 32'h1, 4'hf, ZPC_RESP_OKAY);
		arm(0, 1);
		scale.step(0, 1'b1, 1);
		scale.pulse_mark(0);
		check("ref", 32'(ref_ind), 32'h1);
		check("hold", 32'(hold_ind), 32'h1);
		press(ZPC_IN_RST_A);
		check("hold", 32'(hold_ind), 32'h0);
		rd(ZPC_REG_STORED0, 32'h0);
		rd(ZPC_REG_POS0, 32'h1);
		end_of_test();
	end
endmodule : test_zero_point_counter_control

/* tb/zpc_scale_model.sv */
// behavioural scale model: zero-mark and count-step pins for both axes
`timescale 1ns/1ps
module zpc_scale_model (
	input wire logic aclk,
	output logic [1:0] zero_mark,
	output logic [1:0] count_up,
	output logic [1:0] count_dn
);
	initial begin
		zero_mark = 2'h0;
		count_up = 2'h0;
		count_dn = 2'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// pins stay high two cycles so the two-flop synchroniser cannot miss them
	task automatic pulse_mark(input int ax);
		@(posedge aclk);
		zero_mark[ax] <= 1'b1;
		repeat (2) @(posedge aclk);
		zero_mark[ax] <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : pulse_mark

	task automatic step(input int ax, input logic up, input int n);
		repeat (n) begin
			@(posedge aclk);
			if (up) begin
				count_up[ax] <= 1'b1;
			end else begin
				count_dn[ax] <= 1'b1;
			end
			repeat (2) @(posedge aclk);
			count_up[ax] <= 1'b0;
			count_dn[ax] <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
	endtask : step
endmodule : zpc_scale_model
